// ==== design/pwl_pkg.sv ====
// Shared offsets, field positions, reset values and bus carriers for the wakeup timer block
package pwl_pkg;

	// Word indices of the registers; byte address is index times four
	localparam logic [5:0] IDX_LOWVOLT = 6'h00;
	localparam logic [5:0] IDX_TIMER = 6'h01;
	localparam logic [5:0] IDX_TRIM = 6'h02;
	localparam logic [5:0] IDX_RATE = 6'h03;

	// Low-voltage register fields
	localparam int LV_STATUS_BIT = 2;
	localparam int LV_IE_BIT = 1;
	localparam int LV_FLAG_BIT = 0;

	// Periodic timer control fields
	localparam int TM_CLKSEL_BIT = 7;
	localparam int TM_WAVE_BIT = 4;
	localparam int TM_EXT_BIT = 3;
	localparam int TM_FE_BIT = 2;
	localparam int TM_IE_BIT = 1;
	localparam int TM_FLAG_BIT = 0;

	// Trim field position
	localparam int TRIM_LSB = 2;
	localparam int TRIM_MSB = 7;

	// Values after reset
	localparam logic [15:0] RATE_RESET = 16'h0000;
	localparam logic [5:0] TRIM_RESET = 6'h00;
	localparam logic [16:0] COUNT_RESET = 17'h0_0000;

	// Bus response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Master to slave signals of the register bus
	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} axi_req_t;

	// Slave to master signals of the register bus
	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} axi_rsp_t;

	localparam axi_rsp_t RSP_RESET = '{awready: 1'b1, wready: 1'b1, bresp: 2'h0, bvalid: 1'b0,
		arready: 1'b1, rdata: 32'h0000_0000, rresp: 2'h0, rvalid: 1'b0};

endpackage

// ==== design/sync_filter.sv ====
// Three-stage input synchroniser with agreement filter and change pulse
`timescale 1ns/1ps
module sync_filter (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic async_in,
	output logic level_out,
	output logic change_out
);
	logic s1_reg, s2_reg, s3_reg, level_reg, change_reg;
	logic level_next, change_next;

	// A change counts only once stages two and three agree
	always_comb begin
		change_next = (s2_reg == s3_reg) && (s3_reg != level_reg);
		level_next = change_next ? s3_reg : level_reg;
	end

	// First stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
			change_reg <= 1'b0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
			change_reg <= change_next;
		end
	end

	assign level_out = level_reg;
	assign change_out = change_reg;
endmodule // sync_filter

// ==== design/periodic_wakeup_and_lowvolt_flag.sv ====
// Low-voltage change flag, periodic wakeup timer and RC trim register behind an AXI4-Lite slave
`timescale 1ns/1ps
module periodic_wakeup_and_lowvolt_flag (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire pwl_pkg::axi_req_t axi_req_in,
	output pwl_pkg::axi_rsp_t axi_rsp_out,
	input wire logic rc_clock_in,
	input wire logic lowvolt_detect_in,
	input wire logic full_performance_mode_in,
	input wire logic trim_flash_valid_in,
	input wire logic [5:0] trim_flash_value_in,
	output logic [5:0] rc_trim_field_out,
	output logic lowvolt_irq_out,
	output logic timer_irq_out,
	output logic external_timer_pin_out
);
	// Low-voltage state
	logic lowvolt_irq_enable_reg, lowvolt_irq_enable_next;
	logic lowvolt_change_flag_reg, lowvolt_change_flag_next;
	logic lowvolt_irq_reg, lowvolt_irq_next;
	logic lowvolt_status, lowvolt_changed;
	// Timer control state
	logic timer_clock_select_reg, timer_clock_select_next;
	logic waveform_select_reg, waveform_select_next;
	logic external_output_enable_reg, external_output_enable_next;
	logic timer_feature_enable_reg, timer_feature_enable_next;
	logic timer_irq_enable_reg, timer_irq_enable_next;
	logic timer_flag_reg, timer_flag_next;
	logic [15:0] timer_rate_value_reg, timer_rate_value_next;
	logic [5:0] rc_trim_field_reg, rc_trim_field_next;
	logic trim_loaded_reg, trim_loaded_next;
	// Timer datapath state
	logic [16:0] count_reg, count_next;
	logic rc_div_reg, rc_div_next;
	logic square_reg, square_next;
	logic pulse_reg, pulse_next;
	logic pin_reg, pin_next;
	logic timer_irq_reg, timer_irq_next;
	logic rc_level, rc_change, rc_rise, tick, period_end;
	// Bus state
	logic aw_held_reg, aw_held_next;
	logic [5:0] aw_idx_reg, aw_idx_next;
	logic w_held_reg, w_held_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	pwl_pkg::axi_rsp_t rsp_reg, rsp_next;
	logic wr_do, ar_take, lane0;

	// Valid register word index
	function automatic logic idx_hit(input logic [5:0] idx);
		idx_hit = (idx == pwl_pkg::IDX_LOWVOLT) || (idx == pwl_pkg::IDX_TIMER) ||
			(idx == pwl_pkg::IDX_TRIM) || (idx == pwl_pkg::IDX_RATE);
	endfunction

	// Supply comparator qualified by performance mode before crossing in
	sync_filter lowvolt_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in(lowvolt_detect_in & full_performance_mode_in),
		.level_out(lowvolt_status),
		.change_out(lowvolt_changed)
	);

	// RC clock is sampled as a slow input, never used as a clock
	sync_filter rc_clock_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in(rc_clock_in),
		.level_out(rc_level),
		.change_out(rc_change)
	);

	// Tick: one bus cycle, or every second RC rising edge
	always_comb begin
		rc_rise = rc_change & rc_level;
		if (timer_clock_select_reg) begin
			tick = timer_feature_enable_reg;
		end else begin
			tick = timer_feature_enable_reg & rc_rise & rc_div_reg;
		end
		period_end = tick && (count_reg == {timer_rate_value_reg, 1'b1});
	end

	// Period counter and waveforms
	always_comb begin
		count_next = count_reg;
		rc_div_next = rc_div_reg;
		square_next = square_reg;
		pulse_next = pulse_reg;
		if (!timer_feature_enable_reg) begin
			count_next = pwl_pkg::COUNT_RESET;
			rc_div_next = 1'b0;
			square_next = 1'b0;
			pulse_next = 1'b0;
		end else begin
			if (rc_rise) begin
				rc_div_next = ~rc_div_reg;
			end
			if (period_end) begin
				count_next = pwl_pkg::COUNT_RESET;
				square_next = ~square_reg;
				pulse_next = 1'b1;
			end else if (tick) begin
				count_next = count_reg + 17'h0_0001;
				pulse_next = 1'b0;
			end
		end
		// Pin stays low unless both enables are set
		if (timer_feature_enable_reg && external_output_enable_reg) begin
			pin_next = waveform_select_reg ? square_next : pulse_next;
		end else begin
			pin_next = 1'b0;
		end
	end

	// Bus handshakes: one write and one read held at a time
	always_comb begin
		rsp_next = rsp_reg;
		aw_idx_next = aw_idx_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		wr_do = aw_held_reg && w_held_reg && !rsp_reg.bvalid;
		ar_take = axi_req_in.arvalid && rsp_reg.arready;
		aw_held_next = aw_held_reg ? !wr_do : (axi_req_in.awvalid && rsp_reg.awready);
		w_held_next = w_held_reg ? !wr_do : (axi_req_in.wvalid && rsp_reg.wready);
		if (!aw_held_reg && axi_req_in.awvalid && rsp_reg.awready) begin
			aw_idx_next = axi_req_in.awaddr[7:2];
		end
		if (!w_held_reg && axi_req_in.wvalid && rsp_reg.wready) begin
			wdata_next = axi_req_in.wdata;
			wstrb_next = axi_req_in.wstrb;
		end
		rsp_next.awready = !aw_held_next;
		rsp_next.wready = !w_held_next;
		rsp_next.bvalid = wr_do || (rsp_reg.bvalid && !axi_req_in.bready);
		if (wr_do) begin
			rsp_next.bresp = idx_hit(aw_idx_reg) ? pwl_pkg::RESP_OKAY : pwl_pkg::RESP_SLVERR;
		end
		rsp_next.rvalid = ar_take || (rsp_reg.rvalid && !axi_req_in.rready);
		rsp_next.arready = !rsp_next.rvalid;
		if (ar_take) begin
			rsp_next.rresp = idx_hit(axi_req_in.araddr[7:2]) ? pwl_pkg::RESP_OKAY : pwl_pkg::RESP_SLVERR;
			rsp_next.rdata = 32'h0000_0000;
			unique case (axi_req_in.araddr[7:2])
				pwl_pkg::IDX_LOWVOLT: begin
					rsp_next.rdata[pwl_pkg::LV_STATUS_BIT] = lowvolt_status;
					rsp_next.rdata[pwl_pkg::LV_IE_BIT] = lowvolt_irq_enable_reg;
					rsp_next.rdata[pwl_pkg::LV_FLAG_BIT] = lowvolt_change_flag_reg;
				end
				pwl_pkg::IDX_TIMER: begin
					rsp_next.rdata[pwl_pkg::TM_CLKSEL_BIT] = timer_clock_select_reg;
					rsp_next.rdata[pwl_pkg::TM_WAVE_BIT] = waveform_select_reg;
					rsp_next.rdata[pwl_pkg::TM_EXT_BIT] = external_output_enable_reg;
					rsp_next.rdata[pwl_pkg::TM_FE_BIT] = timer_feature_enable_reg;
					rsp_next.rdata[pwl_pkg::TM_IE_BIT] = timer_irq_enable_reg;
					rsp_next.rdata[pwl_pkg::TM_FLAG_BIT] = timer_flag_reg;
				end
				pwl_pkg::IDX_TRIM: begin
					rsp_next.rdata[pwl_pkg::TRIM_MSB:pwl_pkg::TRIM_LSB] = rc_trim_field_reg;
				end
				pwl_pkg::IDX_RATE: begin
					rsp_next.rdata[15:0] = timer_rate_value_reg;
				end
				default: begin
					rsp_next.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Register writes; hardware set wins over a same-cycle clear
	always_comb begin
		lane0 = wr_do && wstrb_reg[0];
		lowvolt_irq_enable_next = lowvolt_irq_enable_reg;
		lowvolt_change_flag_next = lowvolt_change_flag_reg;
		timer_clock_select_next = timer_clock_select_reg;
		waveform_select_next = waveform_select_reg;
		external_output_enable_next = external_output_enable_reg;
		timer_feature_enable_next = timer_feature_enable_reg;
		timer_irq_enable_next = timer_irq_enable_reg;
		timer_flag_next = timer_flag_reg;
		timer_rate_value_next = timer_rate_value_reg;
		rc_trim_field_next = rc_trim_field_reg;
		trim_loaded_next = trim_loaded_reg;
		// Flash value arrives once after reset; later software writes may override
		if (!trim_loaded_reg && trim_flash_valid_in) begin
			rc_trim_field_next = trim_flash_value_in;
			trim_loaded_next = 1'b1;
		end
		if (lane0 && aw_idx_reg == pwl_pkg::IDX_LOWVOLT) begin
			lowvolt_irq_enable_next = wdata_reg[pwl_pkg::LV_IE_BIT];
			if (wdata_reg[pwl_pkg::LV_FLAG_BIT]) begin
				lowvolt_change_flag_next = 1'b0;
			end
		end
		if (lane0 && aw_idx_reg == pwl_pkg::IDX_TIMER) begin
			// Source must not switch under a running count
			if (!timer_feature_enable_reg && !wdata_reg[pwl_pkg::TM_FE_BIT]) begin
				timer_clock_select_next = wdata_reg[pwl_pkg::TM_CLKSEL_BIT];
			end
			waveform_select_next = wdata_reg[pwl_pkg::TM_WAVE_BIT];
			external_output_enable_next = wdata_reg[pwl_pkg::TM_EXT_BIT];
			timer_feature_enable_next = wdata_reg[pwl_pkg::TM_FE_BIT];
			timer_irq_enable_next = wdata_reg[pwl_pkg::TM_IE_BIT];
			if (wdata_reg[pwl_pkg::TM_FLAG_BIT]) begin
				timer_flag_next = 1'b0;
			end
		end
		if (lane0 && aw_idx_reg == pwl_pkg::IDX_TRIM) begin
			rc_trim_field_next = wdata_reg[pwl_pkg::TRIM_MSB:pwl_pkg::TRIM_LSB];
		end
		if (wr_do && aw_idx_reg == pwl_pkg::IDX_RATE && !timer_feature_enable_reg) begin
			if (wstrb_reg[0]) begin
				timer_rate_value_next[7:0] = wdata_reg[7:0];
			end
			if (wstrb_reg[1]) begin
				timer_rate_value_next[15:8] = wdata_reg[15:8];
			end
		end
		if (lowvolt_changed) begin
			lowvolt_change_flag_next = 1'b1;
		end
		if (period_end) begin
			timer_flag_next = 1'b1;
		end
		// Requests follow the flags one cycle later, from flops
		lowvolt_irq_next = lowvolt_irq_enable_reg & lowvolt_change_flag_reg;
		timer_irq_next = timer_irq_enable_reg & timer_flag_reg;
	end

	// State registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lowvolt_irq_enable_reg <= 1'b0;
			lowvolt_change_flag_reg <= 1'b0;
			lowvolt_irq_reg <= 1'b0;
			timer_clock_select_reg <= 1'b0;
			waveform_select_reg <= 1'b0;
			external_output_enable_reg <= 1'b0;
			timer_feature_enable_reg <= 1'b0;
			timer_irq_enable_reg <= 1'b0;
			timer_flag_reg <= 1'b0;
			timer_rate_value_reg <= pwl_pkg::RATE_RESET;
			rc_trim_field_reg <= pwl_pkg::TRIM_RESET;
			trim_loaded_reg <= 1'b0;
			count_reg <= pwl_pkg::COUNT_RESET;
			rc_div_reg <= 1'b0;
			square_reg <= 1'b0;
			pulse_reg <= 1'b0;
			pin_reg <= 1'b0;
			timer_irq_reg <= 1'b0;
			aw_held_reg <= 1'b0;
			aw_idx_reg <= 6'h00;
			w_held_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			rsp_reg <= pwl_pkg::RSP_RESET;
		end else begin
			lowvolt_irq_enable_reg <= lowvolt_irq_enable_next;
			lowvolt_change_flag_reg <= lowvolt_change_flag_next;
			lowvolt_irq_reg <= lowvolt_irq_next;
			timer_clock_select_reg <= timer_clock_select_next;
			waveform_select_reg <= waveform_select_next;
			external_output_enable_reg <= external_output_enable_next;
			timer_feature_enable_reg <= timer_feature_enable_next;
			timer_irq_enable_reg <= timer_irq_enable_next;
			timer_flag_reg <= timer_flag_next;
			timer_rate_value_reg <= timer_rate_value_next;
			rc_trim_field_reg <= rc_trim_field_next;
			trim_loaded_reg <= trim_loaded_next;
			count_reg <= count_next;
			rc_div_reg <= rc_div_next;
			square_reg <= square_next;
			pulse_reg <= pulse_next;
			pin_reg <= pin_next;
			timer_irq_reg <= timer_irq_next;
			aw_held_reg <= aw_held_next;
			aw_idx_reg <= aw_idx_next;
			w_held_reg <= w_held_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			rsp_reg <= rsp_next;
		end
	end

	// Outputs straight from flops
	assign axi_rsp_out = rsp_reg;
	assign rc_trim_field_out = rc_trim_field_reg;
	assign lowvolt_irq_out = lowvolt_irq_reg;
	assign timer_irq_out = timer_irq_reg;
	assign external_timer_pin_out = pin_reg;
endmodule // periodic_wakeup_and_lowvolt_flag

// ==== tb/pwl_properties.sv ====
// Bus timing and output checks for the wakeup timer block
`timescale 1ns/1ps
module pwl_properties (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire pwl_pkg::axi_req_t axi_req_in,
	input wire pwl_pkg::axi_rsp_t axi_rsp_out,
	input wire logic trim_flash_valid_in,
	input wire logic [5:0] rc_trim_field_out,
	input wire logic lowvolt_irq_out,
	input wire logic timer_irq_out,
	input wire logic external_timer_pin_out
);
	// One clock domain, muted in reset except the reset check itself
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	chk_reset_quiet: assert property (disable iff (1'b0) rst_in |=>
		!lowvolt_irq_out && !timer_irq_out && !external_timer_pin_out && rc_trim_field_out == 6'h00)
		else $error("outputs not quiet after reset");
	chk_read_answer: assert property (axi_req_in.arvalid && axi_rsp_out.arready |=>
		axi_rsp_out.rvalid && !axi_rsp_out.arready) else $error("read answer late");
	chk_read_hold: assert property (axi_rsp_out.rvalid && !axi_req_in.rready |=>
		axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata) && $stable(axi_rsp_out.rresp))
		else $error("read answer dropped");
	chk_write_answer: assert property (axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid
		&& axi_rsp_out.wready |-> ##2 axi_rsp_out.bvalid) else $error("write answer late");
	chk_write_hold: assert property (axi_rsp_out.bvalid && !axi_req_in.bready |=>
		axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp)) else $error("write answer dropped");
	chk_err_data: assert property (axi_rsp_out.rvalid && axi_rsp_out.rresp != pwl_pkg::RESP_OKAY |->
		axi_rsp_out.rdata == 32'h0000_0000) else $error("error read carries data");
	chk_upper_zero: assert property (axi_rsp_out.rvalid |-> axi_rsp_out.rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	// Trim moves only on a performed write or a flash load
	chk_trim_cause: assert property ($changed(rc_trim_field_out) |->
		$rose(axi_rsp_out.bvalid) || $past(trim_flash_valid_in)) else $error("trim changed unprompted");
endmodule // pwl_properties

bind periodic_wakeup_and_lowvolt_flag pwl_properties chk_u (.clk_in(clk_in), .rst_in(rst_in),
	.axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out), .trim_flash_valid_in(trim_flash_valid_in),
	.rc_trim_field_out(rc_trim_field_out), .lowvolt_irq_out(lowvolt_irq_out),
	.timer_irq_out(timer_irq_out), .external_timer_pin_out(external_timer_pin_out));

// ==== tb/tb.sv ====
// Self-checking bench for the wakeup timer block with a register model
`timescale 1ns/1ps
module tb;
	logic clk_in = 0;
	logic rst_in = 1;
	pwl_pkg::axi_req_t q = '0;
	pwl_pkg::axi_rsp_t p;
	logic rc_clk = 0, lvd = 0, full_performance_mode = 0, tfv = 0;
	logic [5:0] tv = 6'h00, trim, v;
	logic lv_irq, tm_irq, pin;
	int err_count = 0, num_checks = 0;
	int m[4] = '{default: 0};
	int r, hi, per;

	periodic_wakeup_and_lowvolt_flag dut_u (.clk_in(clk_in), .rst_in(rst_in), .axi_req_in(q), .axi_rsp_out(p),
		.rc_clock_in(rc_clk), .lowvolt_detect_in(lvd), .full_performance_mode_in(full_performance_mode), .trim_flash_valid_in(tfv),
		.trim_flash_value_in(tv), .rc_trim_field_out(trim), .lowvolt_irq_out(lv_irq), .timer_irq_out(tm_irq),
		.external_timer_pin_out(pin));

	initial forever #5 clk_in = ~clk_in;
	// RC clock ten bus cycles long, offset so its edges never meet the bus clock
	initial begin
		#2;
		forever #50 rc_clk = ~rc_clk;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task test_done;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Write; the model follows the documented write rules
	task wr(input logic [31:0] a, input logic [31:0] d);
		int n, i, f, c;
		logic [1:0] br;
		n = 0;
		i = a[7:2];
		@(posedge clk_in);
		q <= '{awaddr: a, awvalid: 1, wdata: d, wstrb: 4'hF, wvalid: 1, bready: 1, default: 0};
		do begin
			@(posedge clk_in);
			if (p.awready) q.awvalid <= 0;
			if (p.wready) q.wvalid <= 0;
		end while (p.bvalid !== 1 && n++ < 99);
		br = p.bresp;
		chk("bvalid", 1, p.bvalid);
		q.bready <= 0;
		chk("bresp", i < 4 ? 0 : 2, br);
		case (i)
			0: m[0] = (m[0] & 5 & ~(d & 1)) | (d & 2);
			1: begin
				c = (m[1] & 4) || (d & 4) ? m[1] & 128 : d & 128;
				f = d & 1 ? 0 : m[1] & 1;
				m[1] = (d & 30) | c | f;
			end
			2: m[2] = d & 252;
			3: if (!(m[1] & 4)) m[3] = d & 65535;
		endcase
	endtask

	// Read and compare with the model
	task rdc(input logic [31:0] a);
		int n, i;
		n = 0;
		i = a[7:2];
		@(posedge clk_in);
		q <= '{araddr: a, arvalid: 1, rready: 1, default: 0};
		do begin
			@(posedge clk_in);
			if (p.arready) q.arvalid <= 0;
		end while (p.rvalid !== 1 && n++ < 99);
		q.rready <= 0;
		chk("rvalid", 1, p.rvalid);
		chk("rresp", i < 4 ? 0 : 2, p.rresp);
		chk("rdata", i < 4 ? m[i] : 0, p.rdata);
	endtask

	// High time and rise-to-rise time of the timer pin
	task meas;
		int n;
		n = 0;
		while (pin !== 0 && n++ < 999) @(posedge clk_in);
		while (pin !== 1 && n++ < 999) @(posedge clk_in);
		hi = 0;
		while (pin === 1 && hi < 999) begin
			hi++;
			@(posedge clk_in);
		end
		per = hi;
		while (pin !== 1 && per < 999) begin
			per++;
			@(posedge clk_in);
		end
	endtask

	// Main sequence
	initial begin
		void'($urandom(53));
		repeat (5) @(posedge clk_in);
		rst_in <= 0;
		for (int i = 0; i < 5; i++) rdc(i * 4);
		wr(8'h10, 8'hFF);
		v = $urandom;
		tv <= v;
		tfv <= 1;
		@(posedge clk_in);
		tfv <= 0;
		tv <= ~v;
		m[2] = v * 4;
		repeat (2) @(posedge clk_in);
		// A second load strobe must not replace the first value
		tfv <= 1;
		@(posedge clk_in);
		tfv <= 0;
		rdc(8'h08);
		chk("trim", v, trim);
		wr(8'h08, 8'h80);
		chk("trim", 6'h20, trim);
		rdc(8'h08);
		lvd <= 1;
		full_performance_mode <= 1;
		repeat (12) @(posedge clk_in);
		m[0] = 5;
		rdc(8'h00);
		wr(8'h00, 8'h04);
		rdc(8'h00);
		wr(8'h00, 8'h02);
		repeat (2) @(posedge clk_in);
		chk("lv_irq", 1, lv_irq);
		wr(8'h00, 8'h03);
		repeat (2) @(posedge clk_in);
		chk("lv_irq", 0, lv_irq);
		full_performance_mode <= 0;
		repeat (12) @(posedge clk_in);
		m[0] = 3;
		rdc(8'h00);
		chk("lv_irq", 1, lv_irq);
		wr(8'h00, 8'h01);
		rdc(8'h00);
		r = $urandom % 8;
		wr(8'h0C, r);
		rdc(8'h0C);
		wr(8'h04, 8'h80);
		rdc(8'h04);
		wr(8'h04, 8'h8E);
		meas;
		m[1] |= 1;
		chk("pulse", 1, hi);
		chk("period", 2 * r + 2, per);
		chk("tm_irq", 1, tm_irq);
		wr(8'h0C, r + 1);
		rdc(8'h0C);
		wr(8'h04, 8'h1E);
		meas;
		chk("half", 2 * r + 2, hi);
		chk("square", 4 * r + 4, per);
		rdc(8'h04);
		wr(8'h04, 8'h80);
		repeat (2) @(posedge clk_in);
		chk("pin", 0, pin);
		chk("tm_irq", 0, tm_irq);
		rdc(8'h04);
		wr(8'h04, 8'h81);
		rdc(8'h04);
		wr(8'h04, 8'h04);
		repeat (20) @(posedge clk_in);
		chk("pin", 0, pin);
		m[1] |= 1;
		rdc(8'h04);
		wr(8'h04, 8'h00);
		// Re-enable on the bus clock: the first pulse must come a full period after the enabling write
		wr(8'h04, 8'h0C);
		repeat (2 * r + 1) @(posedge clk_in);
		chk("first_pulse", 0, pin);
		@(posedge clk_in);
		chk("first_pulse", 1, pin);
		wr(8'h04, 8'h00);
		wr(8'h04, 8'h01);
		rdc(8'h04);
		wr(8'h0C, 8'h00);
		wr(8'h04, 8'h0C);
		meas;
		chk("rc_pulse", 20, hi);
		chk("rc_period", 40, per);
		test_done;
	end

	// Watchdog far beyond the few hundred cycles the run needs
	initial begin
		#300000;
		err_count++;
		test_done;
	end
endmodule // tb
